// >>> uafe_pkg.sv
// Package: register map, field positions, reset values and helpers
package uafe_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [2:0] OFS_CTRL = 3'h0;
   localparam logic [2:0] OFS_BUF = 3'h1;
   localparam logic [2:0] OFS_SLAVE_ADDRESS = 3'h2;
   localparam logic [2:0] OFS_SMASK = 3'h3;
   localparam logic [2:0] OFS_PWR = 3'h4;
   localparam logic [2:0] OFS_BAUD = 3'h5;
   localparam logic [2:0] OFS_STAT = 3'h6;
   localparam int CTRL_B7 = 7;
   localparam int CTRL_M1 = 6;
   localparam int CTRL_AF = 5;
   localparam int CTRL_REN = 4;
   localparam int CTRL_TB8 = 3;
   localparam int CTRL_RB8 = 2;
   localparam int CTRL_TDF = 1;
   localparam int CTRL_RDF = 0;
   localparam int PWR_FESEL = 6;
   localparam int BAUD_TX_T2 = 0;
   localparam int BAUD_RX_T2 = 1;
   localparam int STAT_TX_BUSY = 0;
   localparam int STAT_RX_BUSY = 1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] DIV_LAST = 4'hF;
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_B = 4'h8;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam logic [8:0] RX_INIT = 9'h1FF;
   typedef enum logic [1:0] {
      TX_IDLE, TX_PEND, TX_START, TX_DATA
   } uafe_tx_state_t;
   typedef enum logic {RX_HUNT, RX_RUN} uafe_rx_state_t;
   function automatic logic uafe_major(input logic a, input logic b,
                                       input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction : uafe_major
   function automatic logic [7:0] uafe_rev8(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction : uafe_rev8
endpackage : uafe_pkg

// >>> uafe_link_if.sv
// Interface: signals between the port top and its shift engines
interface uafe_link_if;
   logic tx_tick;
   logic tx_load;
   logic [7:0] tx_data;
   logic tx_line;
   logic tx_done;
   logic tx_busy;
   logic rx_tick;
   logic rx_enable;
   logic rx_line;
   logic rx_done;
   logic [7:0] rx_data;
   logic rx_stop;
   logic rx_busy;
   modport top_mp(output tx_tick, tx_load, tx_data, rx_tick, rx_enable,
                  rx_line, input tx_line, tx_done, tx_busy, rx_done,
                  rx_data, rx_stop, rx_busy);
   modport tx_mp(input tx_tick, tx_load, tx_data,
                 output tx_line, tx_done, tx_busy);
   modport rx_mp(input rx_tick, rx_enable, rx_line,
                 output rx_done, rx_data, rx_stop, rx_busy);
endinterface : uafe_link_if

// >>> uafe_tx.sv
// Transmit engine: divide-by-16 bit timer and shift register
module uafe_tx (
   input wire logic clock,
   input wire logic rst_sync_b,
   uafe_link_if.tx_mp lk
);
   import uafe_pkg::*;
   uafe_tx_state_t state_reg;
   logic [8:0] shift_reg;
   logic [3:0] div_reg;
   logic roll;
   logic last;
   assign roll = lk.tx_tick && (div_reg == DIV_LAST);
   assign last = (shift_reg[8:2] == 7'h00) && shift_reg[1];
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         div_reg <= 4'h0;
      end else if (lk.tx_tick) begin
         div_reg <= div_reg + 4'h1;
      end
   end
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_reg <= TX_IDLE;
         shift_reg <= 9'h000;
      end else if (lk.tx_load) begin
         shift_reg <= {1'b1, lk.tx_data};
         state_reg <= TX_PEND;
      end else if (roll) begin
         case (state_reg)
            TX_PEND: state_reg <= TX_START;
            TX_START: state_reg <= TX_DATA;
            TX_DATA: begin
               shift_reg <= {1'b0, shift_reg[8:1]};
               if (last) begin
                  state_reg <= TX_IDLE;
               end
            end
            default: state_reg <= TX_IDLE;
         endcase
      end
   end
   assign lk.tx_done = roll && (state_reg == TX_DATA) && last;
   assign lk.tx_line = (state_reg == TX_START) ? 1'b0 :
                       (state_reg == TX_DATA) ? shift_reg[0] : 1'b1;
   assign lk.tx_busy = (state_reg != TX_IDLE);
   a_tx_start_low: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (state_reg == TX_START) |-> !lk.tx_line && shift_reg[8])
      else $error("start not low or data shifted early");
   a_tx_marker_load: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      lk.tx_load |=> shift_reg == {1'b1, $past(lk.tx_data)})
      else $error("marker not loaded");
   a_tx_start_roll: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (state_reg == TX_PEND) ##1 (state_reg == TX_START) |-> $past(roll))
      else $error("start off rollover");
endmodule : uafe_tx

// >>> uafe_rx.sv
// Receive engine: start hunt, 7/8/9 majority sampling, 9-bit shifter
module uafe_rx (
   input wire logic clock,
   input wire logic rst_sync_b,
   uafe_link_if.rx_mp lk
);
   import uafe_pkg::*;
   uafe_rx_state_t state_reg;
   logic [8:0] shift_reg;
   logic [3:0] cnt_reg;
   logic [1:0] smp_reg;
   logic prev_reg;
   logic bit_val;
   logic at_c;
   logic first;
   assign bit_val = uafe_major(smp_reg[0], smp_reg[1], lk.rx_line);
   assign at_c = lk.rx_tick && (state_reg == RX_RUN) && (cnt_reg == SMP_C);
   assign first = (shift_reg == RX_INIT);
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         prev_reg <= 1'b1;
      end else if (lk.rx_tick) begin
         prev_reg <= lk.rx_line;
      end
   end
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_reg <= RX_HUNT;
         shift_reg <= RX_INIT;
         cnt_reg <= 4'h0;
         smp_reg <= 2'b11;
      end else if (lk.rx_tick) begin
         case (state_reg)
            RX_HUNT: begin
               if (lk.rx_enable && prev_reg && !lk.rx_line) begin
                  cnt_reg <= 4'h0;
                  shift_reg <= RX_INIT;
                  state_reg <= RX_RUN;
               end
            end
            RX_RUN: begin
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == SMP_A) smp_reg[0] <= lk.rx_line;
               if (cnt_reg == SMP_B) smp_reg[1] <= lk.rx_line;
               if (cnt_reg == SMP_C) begin
                  if (first && bit_val) begin
                     state_reg <= RX_HUNT;
                  end else if (!shift_reg[8]) begin
                     state_reg <= RX_HUNT;
                  end else begin
                     shift_reg <= {shift_reg[7:0], bit_val};
                  end
               end
            end
            default: state_reg <= RX_HUNT;
         endcase
      end
   end
   assign lk.rx_done = at_c && !first && !shift_reg[8];
   assign lk.rx_data = uafe_rev8(shift_reg[7:0]);
   assign lk.rx_stop = bit_val;
   assign lk.rx_busy = (state_reg == RX_RUN);
   a_rx_ones_init: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (state_reg == RX_HUNT) ##1 (state_reg == RX_RUN) |->
      first && (cnt_reg == 4'h0)) else $error("no 1FF on start");
   a_rx_back_hunt: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      lk.rx_done |=> state_reg == RX_HUNT) else $error("no rehunt");
endmodule : uafe_rx

// >>> uafe_top.sv
// Top: async serial port registers, bit-rate selection and pin logic
module uafe_top (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [uafe_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [uafe_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [uafe_pkg::DATA_W-1:0] reg_rdata,
   input wire logic timer1_overflow,
   input wire logic timer2_overflow,
   input wire logic rxd_pin,
   output logic txd_pin
);
   import uafe_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers

   logic [1:0] rst_pipe_reg;
   logic rst_sync_b;
   logic rxd_meta_reg;
   logic rxd_sync_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_reg <= 2'b00;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe_reg[1];

   // Idle line is high, so the synchroniser resets high to avoid a
   // false start edge right after reset
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
      end else begin
         rxd_meta_reg <= rxd_pin;
         rxd_sync_reg <= rxd_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software-visible state

   logic mode0_reg;
   logic mode1_reg;
   logic filt_en_reg;
   logic rx_en_reg;
   logic tx_ninth_reg;
   logic rx_ninth_reg;
   logic tdf_reg;
   logic rdf_reg;
   logic fe_reg;
   logic fe_sel_reg;
   logic [7:0] pwr_rest_reg;
   logic [1:0] baud_reg;
   logic [7:0] rx_buf_reg;
   logic [7:0] slave_address_reg;
   logic [7:0] smask_reg;
   logic [7:0] rdata_reg;
   logic txd_reg;

   logic wr_ctrl;
   logic wr_buf;
   logic wr_pwr;
   logic accept;
   logic filt_active;
   logic addr_hit;
   logic [7:0] given_addr;
   logic [7:0] bcast_addr;
   logic [7:0] ctrl_view;

   uafe_link_if lk();

   assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
   assign wr_buf = reg_wr && (reg_addr == OFS_BUF);
   assign wr_pwr = reg_wr && (reg_addr == OFS_PWR);

   ////////////////////////////////////////////////////////////////////////
   // Bit-rate tick selection

   // Both timers pulse in this clock domain, so no synchroniser here
   always_comb begin
      lk.tx_tick = baud_reg[BAUD_TX_T2] ? timer2_overflow
                                        : timer1_overflow;
      lk.rx_tick = baud_reg[BAUD_RX_T2] ? timer2_overflow
                                        : timer1_overflow;
   end

   assign lk.tx_load = wr_buf;
   assign lk.tx_data = reg_wdata;
   assign lk.rx_enable = rx_en_reg;
   assign lk.rx_line = rxd_sync_reg;

   uafe_tx u_tx (
      .clock(clock),
      .rst_sync_b(rst_sync_b),
      .lk(lk.tx_mp)
   );

   uafe_rx u_rx (
      .clock(clock),
      .rst_sync_b(rst_sync_b),
      .lk(lk.rx_mp)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address recognition and frame acceptance

   assign given_addr = slave_address_reg & smask_reg;
   assign bcast_addr = slave_address_reg | smask_reg;
   // Given: only mask-one positions compared; broadcast: zero positions
   // of the broadcast pattern are ignored
   assign addr_hit = (((lk.rx_data ^ given_addr) & smask_reg) == 8'h00)
                  || (((lk.rx_data ^ bcast_addr) & bcast_addr) == 8'h00);
   assign filt_active = filt_en_reg && (mode0_reg || mode1_reg);
   // Stop bit doubles as the ninth bit, so an address byte from the
   // remote master must carry a one there
   assign accept = !rdf_reg && (!filt_active ||
                   (lk.rx_stop && addr_hit));

   ////////////////////////////////////////////////////////////////////////
   // Control register and flags

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         mode0_reg <= RST_BYTE[CTRL_B7];
         mode1_reg <= RST_BYTE[CTRL_M1];
         filt_en_reg <= RST_BYTE[CTRL_AF];
         rx_en_reg <= RST_BYTE[CTRL_REN];
         tx_ninth_reg <= RST_BYTE[CTRL_TB8];
      end else if (wr_ctrl) begin
         if (!fe_sel_reg) begin
            mode0_reg <= reg_wdata[CTRL_B7];
         end
         mode1_reg <= reg_wdata[CTRL_M1];
         filt_en_reg <= reg_wdata[CTRL_AF];
         rx_en_reg <= reg_wdata[CTRL_REN];
         tx_ninth_reg <= reg_wdata[CTRL_TB8];
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         tdf_reg <= RST_BYTE[CTRL_TDF];
      end else if (lk.tx_done) begin
         tdf_reg <= 1'b1;
      end else if (wr_ctrl) begin
         tdf_reg <= reg_wdata[CTRL_TDF];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdf_reg <= RST_BYTE[CTRL_RDF];
      end else if (lk.rx_done && accept) begin
         rdf_reg <= 1'b1;
      end else if (wr_ctrl) begin
         rdf_reg <= reg_wdata[CTRL_RDF];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rx_buf_reg <= RST_BYTE;
         rx_ninth_reg <= RST_BYTE[CTRL_RB8];
      end else if (lk.rx_done && accept) begin
         rx_buf_reg <= lk.rx_data;
         rx_ninth_reg <= lk.rx_stop;
      end else if (wr_ctrl) begin
         rx_ninth_reg <= reg_wdata[CTRL_RB8];
      end
   end

   // Framing error is set whatever the view select; only software clears
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fe_reg <= 1'b0;
      end else if (lk.rx_done && !lk.rx_stop) begin
         fe_reg <= 1'b1;
      end else if (wr_ctrl && fe_sel_reg) begin
         fe_reg <= reg_wdata[CTRL_B7];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power control, baud select, address registers

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fe_sel_reg <= RST_BYTE[PWR_FESEL];
         pwr_rest_reg <= RST_BYTE;
      end else if (wr_pwr) begin
         fe_sel_reg <= reg_wdata[PWR_FESEL];
         pwr_rest_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         baud_reg <= RST_BYTE[1:0];
         slave_address_reg <= RST_BYTE;
         smask_reg <= RST_BYTE;
      end else if (reg_wr) begin
         if (reg_addr == OFS_BAUD) baud_reg <= reg_wdata[1:0];
         if (reg_addr == OFS_SLAVE_ADDRESS) slave_address_reg <= reg_wdata;
         if (reg_addr == OFS_SMASK) smask_reg <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path: data valid only in the cycle after the read strobe
   // Zero outside the answer cycle, so a master that samples late sees
   // an obviously empty bus rather than stale data

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[CTRL_B7] = fe_sel_reg ? fe_reg : mode0_reg;
      ctrl_view[CTRL_M1] = mode1_reg;
      ctrl_view[CTRL_AF] = filt_en_reg;
      ctrl_view[CTRL_REN] = rx_en_reg;
      ctrl_view[CTRL_TB8] = tx_ninth_reg;
      ctrl_view[CTRL_RB8] = rx_ninth_reg;
      ctrl_view[CTRL_TDF] = tdf_reg;
      ctrl_view[CTRL_RDF] = rdf_reg;
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL: rdata_reg <= ctrl_view;
            OFS_BUF: rdata_reg <= rx_buf_reg;
            OFS_SLAVE_ADDRESS: rdata_reg <= slave_address_reg;
            OFS_SMASK: rdata_reg <= smask_reg;
            OFS_PWR: begin
               rdata_reg <= pwr_rest_reg;
               rdata_reg[PWR_FESEL] <= fe_sel_reg;
            end
            OFS_BAUD: rdata_reg <= {6'h00, baud_reg};
            OFS_STAT: begin
               rdata_reg <= 8'h00;
               rdata_reg[STAT_TX_BUSY] <= lk.tx_busy;
               rdata_reg[STAT_RX_BUSY] <= lk.rx_busy;
            end
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Transmit pin, registered so the output comes from a flip-flop
   // One cycle of pin latency buys a glitch-free output; bit lengths
   // are unaffected

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         txd_reg <= 1'b1;
      end else begin
         txd_reg <= lk.tx_line;
      end
   end
   assign txd_pin = txd_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_rx_accept_load: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (lk.rx_done && accept) |=> rdf_reg && (rx_buf_reg == $past(lk.rx_data)))
      else $error("accepted frame not loaded");

   a_rx_full_drop: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (lk.rx_done && rdf_reg) |=> $stable(rx_buf_reg))
      else $error("frame overwrote full buffer");

   a_filter_miss: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (lk.rx_done && filt_active && !addr_hit && !rdf_reg) |=>
      !rdf_reg || $past(wr_ctrl))
      else $error("unmatched address accepted");

   a_fe_on_stop: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (lk.rx_done && !lk.rx_stop) |=> fe_reg)
      else $error("framing error not set");

   a_fe_sw_only: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (fe_reg && !(wr_ctrl && fe_sel_reg)) |=> fe_reg)
      else $error("framing error cleared by hardware");

   a_tdf_done_set: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      lk.tx_done |=> tdf_reg ##1 (tdf_reg || $past(wr_ctrl)))
      else $error("transmit-done not set");

   a_bit7_view: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (reg_rd && reg_addr == OFS_CTRL) |=>
      reg_rdata[CTRL_B7] == ($past(fe_sel_reg) ? $past(fe_reg)
                                               : $past(mode0_reg)))
      else $error("bit 7 view wrong");

   a_mode0_nofilt: assert property (@(posedge clock)
      disable iff (!rst_sync_b)
      (lk.rx_done && !rdf_reg && !mode0_reg && !mode1_reg) |=> rdf_reg)
      else $error("frame filtered in mode 0");

endmodule : uafe_top

// >>> uafe_remote.sv
// Remote serial transceiver model facing the frame engine pins
module uafe_remote #(
   parameter int BIT_CLKS = 64
) (
   input wire logic clock,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got_byte = 8'h00;
   logic got_stop = 1'b0;
   initial line_out = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   // Sender: line always returns high, so an idle line is never a start
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         line_out <= f[i];
         repeat (BIT_CLKS - 1) @(posedge clock);
      end
      @(posedge clock);
      line_out <= 1'b1;
   endtask : send
   // Short low glitch, too brief to pass as a start bit
   task automatic pulse(input int n);
      @(posedge clock);
      line_out <= 1'b0;
      repeat (n) @(posedge clock);
      line_out <= 1'b1;
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////
   // Receiver samples mid-bit; a start that is not low is ignored
   always begin : rx_loop
      logic [7:0] b;
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clock);
      if (line_in === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clock);
            b[i] = line_in;
         end
         repeat (BIT_CLKS) @(posedge clock);
         got_stop = line_in;
         got_byte = b;
      end
   end
endmodule : uafe_remote

// >>> uafe_top_tb.sv
// Self-checking bench for the async serial frame engine
module uafe_top_tb;
   import uafe_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic timer1_overflow = 1'b0;
   logic timer2_overflow = 1'b0;
   logic rxd_pin;
   logic txd_pin;
   logic [1:0] tick_cnt = 2'h0;
   // The tx, rx and address scenarios silence the timer they must not use, so a wrong tick
   // select stalls the link instead of passing unnoticed
   logic t1_on = 1'b1;
   logic t2_on = 1'b1;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   always #20 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   // Two timers, same rate, different phase: bit time is 64 clocks
   always @(posedge clock) begin
      tick_cnt <= tick_cnt + 2'h1;
      timer1_overflow <= t1_on && (tick_cnt == 2'h3);
      timer2_overflow <= t2_on && (tick_cnt == 2'h1);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end
   uafe_top uafe_top_inst (.clock(clock), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
      .rxd_pin(rxd_pin), .txd_pin(txd_pin));
   uafe_remote #(.BIT_CLKS(64)) uafe_remote_inst (.clock(clock),
      .line_in(txd_pin), .line_out(rxd_pin));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string name, input logic [7:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [2:0] a, input logic [7:0] m, e,
                        input string name);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(name, e, reg_rdata & m);
   endtask : rdchk
   // Frame end plus pin synchroniser and flag update
   task automatic rx_frame(input logic [7:0] d, input logic stop);
      uafe_remote_inst.send(d, stop);
      repeat (8) @(posedge clock);
   endtask : rx_frame
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdchk(OFS_CTRL, 8'hFF, 8'h00, "ctrl reset");
      rdchk(OFS_STAT, 8'hFF, 8'h00, "status reset");
      wr(3'h7, 8'hFF);
      rdchk(3'h7, 8'hFF, 8'h00, "unmapped");
      chk("txd idle", 8'h01, {7'h00, txd_pin});
   endtask : t_reset
   task automatic t_tx();
      int n;
      wr(OFS_BAUD, 8'h02);
      t2_on <= 1'b0;
      wr(OFS_BUF, 8'hA5);
      n = 0;
      while (txd_pin !== 1'b0 && n < 80) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk("start delay", 8'h01, {7'h00, n < 70});
      // Pin fell one cycle after rollover 1; rollover 10 is 576 cycles
      // later, so the flag is read about 15 cycles before it and 7 cycles after it
      rdchk(OFS_STAT, 8'h01, 8'h01, "tx busy");
      repeat (556) @(posedge clock);
      rdchk(OFS_CTRL, 8'h02, 8'h00, "tx early");
      chk("tx last bit", 8'h01, {7'h00, txd_pin});
      repeat (20) @(posedge clock);
      rdchk(OFS_CTRL, 8'h02, 8'h02, "tx done");
      chk("tx stop line", 8'h01, {7'h00, txd_pin});
      repeat (80) @(posedge clock);
      chk("tx byte", 8'hA5, uafe_remote_inst.got_byte);
      chk("tx stop", 8'h01, {7'h00, uafe_remote_inst.got_stop});
      t2_on <= 1'b1;
   endtask : t_tx
   task automatic t_rx();
      t1_on <= 1'b0;
      wr(OFS_CTRL, 8'h10);
      rx_frame(8'h3C, 1'b1);
      rdchk(OFS_CTRL, 8'h05, 8'h05, "rx done");
      rdchk(OFS_BUF, 8'hFF, 8'h3C, "rx byte");
      rx_frame(8'h55, 1'b1);
      rdchk(OFS_BUF, 8'hFF, 8'h3C, "rx held");
      wr(OFS_CTRL, 8'h10);
      uafe_remote_inst.pulse(8);
      // Long enough for a wrongly accepted glitch to finish a frame
      repeat (700) @(posedge clock);
      rdchk(OFS_CTRL, 8'h01, 8'h00, "glitch");
      rx_frame(8'h81, 1'b1);
      rdchk(OFS_BUF, 8'hFF, 8'h81, "rx again");
      t1_on <= 1'b1;
   endtask : t_rx
   task automatic t_frame();
      wr(OFS_PWR, 8'h40);
      wr(OFS_CTRL, 8'h10);
      rx_frame(8'h66, 1'b0);
      rdchk(OFS_CTRL, 8'h80, 8'h80, "fe set");
      repeat (100) @(posedge clock);
      rdchk(OFS_CTRL, 8'h80, 8'h80, "fe kept");
      wr(OFS_PWR, 8'h00);
      rdchk(OFS_CTRL, 8'h80, 8'h00, "mode view");
      wr(OFS_PWR, 8'h40);
      wr(OFS_CTRL, 8'h10);
      rdchk(OFS_CTRL, 8'h80, 8'h00, "fe clear");
      wr(OFS_PWR, 8'h00);
      rx_frame(8'h66, 1'b0);
      wr(OFS_PWR, 8'h40);
      rdchk(OFS_CTRL, 8'h80, 8'h80, "fe hidden");
      wr(OFS_CTRL, 8'h10);
      wr(OFS_PWR, 8'h00);
   endtask : t_frame
   task automatic t_addr();
      logic [7:0] ctl [5] = '{8'h70, 8'h70, 8'h70, 8'h70, 8'h30};
      logic [7:0] dat [5] = '{8'hC2, 8'h41, 8'hFF, 8'hC0, 8'h41};
      logic stp [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      logic [7:0] hit [5] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
      wr(OFS_SLAVE_ADDRESS, 8'hC0);
      wr(OFS_SMASK, 8'hFD);
      wr(OFS_BAUD, 8'h01);
      t2_on <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CTRL, ctl[i]);
         rx_frame(dat[i], stp[i]);
         rdchk(OFS_CTRL, 8'h01, hit[i], "addr match");
      end
   endtask : t_addr
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_tx();
      t_rx();
      t_frame();
      t_addr();
      print_verdict();
   end
endmodule : uafe_top_tb
